// File: hdl/hsep_defines.svh
// Constants for hardware standby entry and pin hold
// Assumes one system clock of 250 MHz shared by both ends
`ifndef HSEP_DEFINES_SVH
`define HSEP_DEFINES_SVH

`define HSEP_CLK_NS          4
`define HSEP_PRE_RESET_CYC   10
`define HSEP_EXIT_NS         100
`define HSEP_EXIT_CYC        ((`HSEP_EXIT_NS + `HSEP_CLK_NS - 1) / `HSEP_CLK_NS)
`define HSEP_RELEASE_NS      0
`define HSEP_RELEASE_CYC     ((`HSEP_RELEASE_NS + `HSEP_CLK_NS - 1) / `HSEP_CLK_NS + 1)
`define HSEP_SYNC_MARGIN     2
`define HSEP_STARTUP_CYC     16

// Device register offsets
`define HSEP_OFS_SYSCTRL     8'h00
`define HSEP_OFS_STATUS      8'h01
`define HSEP_OFS_DIR         8'h02
`define HSEP_OFS_DATA        8'h03
`define HSEP_OFS_PULLUP      8'h04
`define HSEP_OFS_PERIPH      8'h05
`define HSEP_OFS_SB_CTRL     8'h08
`define HSEP_OFS_SB_STAT     8'h09
`define HSEP_OFS_SB_DATA     8'h0a
`define HSEP_OFS_SB_MODE     8'h0b

// Device system control fields and absent-register read value
`define HSEP_SYS_RAM_EN_BIT  0
`define HSEP_SYS_SWSTBY_BIT  1
`define HSEP_ABSENT_READ     8'hff

// Supervisor register offsets and fields
`define HSEP_SUP_OFS_CMD     8'h00
`define HSEP_SUP_OFS_STATUS  8'h01
`define HSEP_SUP_ENTER_BIT   0
`define HSEP_SUP_KEEP_BIT    1
`define HSEP_SUP_EXIT_BIT    2

`endif

// File: hdl/hsep_pkg.sv
// Types shared by both ends
// Assumes hsep_defines.svh holds the numbers
package hsep_pkg;

  typedef enum logic [2:0] {
    HSEP_DEV_RUN,
    HSEP_DEV_SWSTBY,
    HSEP_DEV_RESET,
    HSEP_DEV_HWSTBY,
    HSEP_DEV_STARTUP
  } hsep_dev_state_t;

  typedef enum logic [2:0] {
    HSEP_SUP_IDLE,
    HSEP_SUP_PRE,
    HSEP_SUP_RELEASE,
    HSEP_SUP_STANDBY,
    HSEP_SUP_EXIT_PRE,
    HSEP_SUP_EXIT_HOLD
  } hsep_sup_state_t;

endpackage

// File: hdl/hsep_link_if.sv
// Pin link between reset supervisor and device
// Assumes both ends share one clock
`timescale 1ns/1ps
interface hsep_link_if;
  logic external_reset_pin_n;
  logic standby_request_pin_n;

  modport supervisor (output external_reset_pin_n, output standby_request_pin_n);
  modport device     (input  external_reset_pin_n, input  standby_request_pin_n);
endinterface

// File: hdl/hsep_device.sv
// Device end: standby state, RAM retention and pin hold
// Assumes link pins are asynchronous to clk
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`include "hsep_defines.svh"
module hsep_device
  import hsep_pkg::*;
#(
  parameter int PORT_W     = 8,
  parameter int ADDR_W     = 16,
  parameter bit SB_PRESENT = 1'b1
)(
  input  wire logic              clk,
  input  wire logic              rst_n,
  hsep_link_if.device            link,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic              wake,
  input  wire logic [PORT_W-1:0] periph_out,
  input  wire logic [PORT_W-1:0] periph_oe,
  input  wire logic [ADDR_W-1:0] bus_addr,
  input  wire logic              bus_addr_valid,
  output logic      [PORT_W-1:0] pin_out,
  output logic      [PORT_W-1:0] pin_oe,
  output logic      [PORT_W-1:0] pin_pullup_en,
  output logic      [ADDR_W-1:0] addr_out,
  output logic                   addr_oe,
  output logic                   cpu_reset_n,
  output logic                   ram_kept
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, three stages, change taken when stages 2 and 3 agree
  logic [2:0] xrst_sync_q;
  logic [2:0] sreq_sync_q;
  logic       xrst_n_q;
  logic       sreq_n_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xrst_sync_q <= 3'h7;
      sreq_sync_q <= 3'h7;
    end
    else
    begin
      xrst_sync_q <= {xrst_sync_q[1:0], link.external_reset_pin_n};
      sreq_sync_q <= {sreq_sync_q[1:0], link.standby_request_pin_n};
    end
  end

  wire xrst_agree = xrst_sync_q[2] == xrst_sync_q[1];
  wire sreq_agree = sreq_sync_q[2] == sreq_sync_q[1];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xrst_n_q <= 1'b1;
      sreq_n_q <= 1'b1;
    end
    else
    begin
      if (xrst_agree)
        xrst_n_q <= xrst_sync_q[2];
      if (sreq_agree)
        sreq_n_q <= sreq_sync_q[2];
    end
  end

  wire xrst_d_n  = xrst_agree ? xrst_sync_q[2] : xrst_n_q;
  wire sreq_d_n  = sreq_agree ? sreq_sync_q[2] : sreq_n_q;
  wire xrst_fall = xrst_n_q && !xrst_d_n;
  wire sreq_fall = sreq_n_q && !sreq_d_n;
  wire sreq_rise = !sreq_n_q && sreq_d_n;

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  logic [7:0]        sysctrl_q;
  logic [PORT_W-1:0] dir_q;
  logic [PORT_W-1:0] data_q;
  logic [PORT_W-1:0] pullup_q;
  logic [PORT_W-1:0] periph_q;
  logic [7:0]        sb_q [4];
  hsep_dev_state_t   state_q;
  hsep_dev_state_t   state_d;

  wire hit_sys  = reg_addr == `HSEP_OFS_SYSCTRL;
  wire hit_stat = reg_addr == `HSEP_OFS_STATUS;
  wire hit_dir  = reg_addr == `HSEP_OFS_DIR;
  wire hit_data = reg_addr == `HSEP_OFS_DATA;
  wire hit_pu   = reg_addr == `HSEP_OFS_PULLUP;
  wire hit_per  = reg_addr == `HSEP_OFS_PERIPH;
  wire hit_sb   = reg_addr[7:2] == 6'(`HSEP_OFS_SB_CTRL >> 2);
  wire in_run   = state_q == HSEP_DEV_RUN;
  wire wr_ok    = reg_wr && in_run;
  wire sw_enter = wr_ok && hit_sys && reg_wdata[`HSEP_SYS_SWSTBY_BIT];

  wire [7:0] rd_mux =
    hit_sys  ? {6'h00, 1'b0, sysctrl_q[`HSEP_SYS_RAM_EN_BIT]} :
    hit_stat ? {4'h0, ram_kept, state_q} :
    hit_dir  ? 8'(dir_q) :
    hit_data ? 8'(data_q) :
    hit_pu   ? 8'(pullup_q) :
    hit_per  ? 8'(periph_q) :
    hit_sb   ? (SB_PRESENT ? sb_q[reg_addr[1:0]] : `HSEP_ABSENT_READ) :
    8'h00;

  // Pin reset returns all software registers to their defaults
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sysctrl_q <= 8'h00;
      dir_q     <= '0;
      data_q    <= '0;
      pullup_q  <= '0;
      periph_q  <= '0;
      reg_rdata <= 8'h00;
      for (int i = 0; i < 4; i++)
        sb_q[i] <= 8'h00;
    end
    else if (!xrst_n_q)
    begin
      sysctrl_q <= 8'h00;
      dir_q     <= '0;
      data_q    <= '0;
      pullup_q  <= '0;
      periph_q  <= '0;
      reg_rdata <= 8'h00;
      for (int i = 0; i < 4; i++)
        sb_q[i] <= 8'h00;
    end
    else
    begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
      if (wr_ok && hit_sys)
        sysctrl_q[`HSEP_SYS_RAM_EN_BIT] <= reg_wdata[`HSEP_SYS_RAM_EN_BIT];
      if (wr_ok && hit_dir)
        dir_q <= reg_wdata[PORT_W-1:0];
      if (wr_ok && hit_data)
        data_q <= reg_wdata[PORT_W-1:0];
      if (wr_ok && hit_pu)
        pullup_q <= reg_wdata[PORT_W-1:0];
      if (wr_ok && hit_per)
        periph_q <= reg_wdata[PORT_W-1:0];
      if (wr_ok && hit_sb && SB_PRESENT)
        sb_q[reg_addr[1:0]] <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Retention check: reset lead time before the standby fall
  logic [4:0] lead_q;
  logic       ram_en_snap_q;
  logic [4:0] start_q;
  localparam logic [4:0] LEAD_MIN  = 5'(`HSEP_PRE_RESET_CYC);
  localparam logic [4:0] START_CYC = 5'(`HSEP_STARTUP_CYC);

  wire lead_ok = lead_q >= LEAD_MIN;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lead_q        <= 5'h00;
      ram_en_snap_q <= 1'b0;
      ram_kept      <= 1'b0;
    end
    else
    begin
      if (xrst_fall)
        ram_en_snap_q <= sysctrl_q[`HSEP_SYS_RAM_EN_BIT];
      if (xrst_n_q)
        lead_q <= 5'h00;
      else if (!lead_ok)
        lead_q <= lead_q + 5'h01;
      if (sreq_fall)
        ram_kept <= ram_en_snap_q && !xrst_n_q && lead_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operating state
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      HSEP_DEV_RUN:     state_d = sw_enter ? HSEP_DEV_SWSTBY : HSEP_DEV_RUN;
      HSEP_DEV_SWSTBY:  state_d = wake ? HSEP_DEV_RUN : HSEP_DEV_SWSTBY;
      HSEP_DEV_RESET:   state_d = xrst_n_q ? HSEP_DEV_STARTUP : HSEP_DEV_RESET;
      HSEP_DEV_HWSTBY:  state_d = sreq_rise ? HSEP_DEV_RESET : HSEP_DEV_HWSTBY;
      HSEP_DEV_STARTUP: state_d = (start_q == START_CYC) ? HSEP_DEV_RUN : HSEP_DEV_STARTUP;
      default:          state_d = HSEP_DEV_RESET;
    endcase
    if (!sreq_n_q && state_q != HSEP_DEV_HWSTBY)
      state_d = HSEP_DEV_HWSTBY;
    else if (!xrst_n_q && state_q != HSEP_DEV_HWSTBY)
      state_d = HSEP_DEV_RESET;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q     <= HSEP_DEV_RESET;
      start_q     <= 5'h00;
      cpu_reset_n <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      start_q     <= (state_q == HSEP_DEV_STARTUP) ? start_q + 5'h01 : 5'h00;
      cpu_reset_n <= state_d == HSEP_DEV_RUN || state_d == HSEP_DEV_SWSTBY;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive per state
  wire [PORT_W-1:0] port_oe  = dir_q;
  wire [PORT_W-1:0] run_oe   = (periph_q & periph_oe) | (~periph_q & port_oe);
  wire [PORT_W-1:0] run_out  = (periph_q & periph_out) | (~periph_q & data_q);
  wire [PORT_W-1:0] hold_pu  = ~dir_q & pullup_q;
  // Peripheral pins fall back to port data, port outputs keep level
  wire [PORT_W-1:0] keep_msk = dir_q & ~periph_q;
  wire [PORT_W-1:0] hold_out = (keep_msk & pin_out) | (~keep_msk & data_q);
  wire              off      = state_q == HSEP_DEV_RESET || state_q == HSEP_DEV_HWSTBY
                               || state_q == HSEP_DEV_STARTUP;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_out       <= '0;
      pin_oe        <= '0;
      pin_pullup_en <= '0;
      addr_out      <= '0;
      addr_oe       <= 1'b0;
    end
    else if (off)
    begin
      pin_oe        <= '0;
      pin_pullup_en <= '0;
      addr_oe       <= 1'b0;
    end
    else if (state_q == HSEP_DEV_SWSTBY)
    begin
      pin_out       <= hold_out;
      pin_oe        <= port_oe;
      pin_pullup_en <= hold_pu;
      addr_oe       <= 1'b1;
    end
    else
    begin
      pin_out       <= run_out;
      pin_oe        <= run_oe;
      pin_pullup_en <= hold_pu;
      addr_oe       <= 1'b1;
      if (bus_addr_valid)
        addr_out <= bus_addr;
    end
  end

endmodule

// File: hdl/hsep_supervisor.sv
// Supervisor end: orders reset and standby pins
// Assumes device samples pins through three flip-flops
`timescale 1ns/1ps
`include "hsep_defines.svh"
module hsep_supervisor
  import hsep_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  hsep_link_if.supervisor link,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            busy
);

  localparam logic [7:0] PRE_CYC  = 8'(`HSEP_PRE_RESET_CYC + `HSEP_SYNC_MARGIN);
  localparam logic [7:0] EXIT_CYC = 8'(`HSEP_EXIT_CYC);
  localparam logic [7:0] REL_CYC  = 8'(`HSEP_RELEASE_CYC + `HSEP_SYNC_MARGIN);

  hsep_sup_state_t state_q;
  hsep_sup_state_t state_d;
  logic [7:0]      cnt_q;
  logic            keep_q;

  wire cmd_wr = reg_wr && reg_addr == `HSEP_SUP_OFS_CMD;
  wire enter  = cmd_wr && reg_wdata[`HSEP_SUP_ENTER_BIT];
  wire keep   = reg_wdata[`HSEP_SUP_KEEP_BIT];
  wire leave  = cmd_wr && reg_wdata[`HSEP_SUP_EXIT_BIT];
  wire hit_st = reg_addr == `HSEP_SUP_OFS_STATUS;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      HSEP_SUP_IDLE:
        if (enter)
          state_d = keep ? HSEP_SUP_PRE : HSEP_SUP_STANDBY;
      HSEP_SUP_PRE:
        if (cnt_q == PRE_CYC)
          state_d = HSEP_SUP_RELEASE;
      HSEP_SUP_RELEASE:
        if (cnt_q == REL_CYC)
          state_d = HSEP_SUP_STANDBY;
      HSEP_SUP_STANDBY:
        if (leave)
          state_d = HSEP_SUP_EXIT_PRE;
      HSEP_SUP_EXIT_PRE:
        if (cnt_q == EXIT_CYC)
          state_d = HSEP_SUP_EXIT_HOLD;
      HSEP_SUP_EXIT_HOLD:
        if (cnt_q == REL_CYC)
          state_d = HSEP_SUP_IDLE;
      default:
        state_d = HSEP_SUP_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= HSEP_SUP_IDLE;
      cnt_q   <= 8'h00;
      keep_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= (state_d != state_q) ? 8'h00 : cnt_q + 8'h01;
      if (enter && state_q == HSEP_SUP_IDLE)
        keep_q <= keep;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive and status
  wire xrst_low = state_d == HSEP_SUP_PRE || state_d == HSEP_SUP_RELEASE
                  || state_d == HSEP_SUP_EXIT_PRE || state_d == HSEP_SUP_EXIT_HOLD;
  // Standby stays low through the whole release wait
  wire sreq_low = state_d == HSEP_SUP_RELEASE || state_d == HSEP_SUP_STANDBY
                  || state_d == HSEP_SUP_EXIT_PRE;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link.external_reset_pin_n  <= 1'b1;
      link.standby_request_pin_n <= 1'b1;
      reg_rdata                  <= 8'h00;
      busy                       <= 1'b0;
    end
    else
    begin
      link.external_reset_pin_n  <= !xrst_low;
      link.standby_request_pin_n <= !sreq_low;
      reg_rdata                  <= (reg_rd && hit_st) ? {4'h0, keep_q, state_q} : 8'h00;
      busy                       <= state_d != HSEP_SUP_IDLE && state_d != HSEP_SUP_STANDBY;
    end
  end

endmodule

// File: bench/hsep_checker.sv
// Checker for the reset and standby pins between supervisor and device
// Assumes one clock domain and takes the link signals as plain inputs
`timescale 1ns/1ps
module hsep_checker (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic external_reset_pin_n,
  input  wire logic standby_request_pin_n
);
  logic [4:0] low_cnt_q;
  logic       rst_prev_q;
  logic       entry_q;

  ////////////////////////////////////////////////////////////////
  // Cycles the reset pin has been low, saturating
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      low_cnt_q  <= 5'h00;
      rst_prev_q <= 1'b1;
      entry_q    <= 1'b0;
    end
    else
    begin
      low_cnt_q  <= external_reset_pin_n ? 5'h00 : (low_cnt_q == 5'h1f ? 5'h1f : low_cnt_q + 5'h01);
      rst_prev_q <= external_reset_pin_n;
      // Reset fell while standby high: an entry is under way
      entry_q    <= standby_request_pin_n && (entry_q || (rst_prev_q && !external_reset_pin_n));
    end
  end

  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  entry_lead_a: assert property ($fell(standby_request_pin_n) && !external_reset_pin_n |-> low_cnt_q >= 5'd10)
    else $error("standby fell too soon after reset");
  entry_span_a: assert property ($fell(external_reset_pin_n) && standby_request_pin_n
    |-> ##[10:20] $fell(standby_request_pin_n))
    else $error("standby did not follow reset in time");
  release_order_a: assert property ($rose(external_reset_pin_n) |-> !entry_q)
    else $error("reset released before standby fell");
  release_bound_a: assert property ($fell(standby_request_pin_n) && !external_reset_pin_n
    |-> ##[1:8] external_reset_pin_n)
    else $error("reset not released after standby entry");
  standby_hold_a: assert property ($fell(standby_request_pin_n) |=> !standby_request_pin_n)
    else $error("standby request glitched after entry");
  plain_entry_a: assert property ($fell(standby_request_pin_n) |-> $stable(external_reset_pin_n))
    else $error("reset moved together with standby");
  exit_lead_a: assert property ($rose(standby_request_pin_n) |-> !external_reset_pin_n && low_cnt_q >= 5'd24)
    else $error("reset lead before standby release too short");
  exit_hold_a: assert property ($rose(standby_request_pin_n) |-> !external_reset_pin_n ##1 !external_reset_pin_n)
    else $error("reset not held across standby release");
  exit_span_a: assert property ($fell(external_reset_pin_n) && !standby_request_pin_n
    |-> ##[20:40] $rose(standby_request_pin_n))
    else $error("standby not released after exit reset");
endmodule

// File: bench/tb_top.sv
// Self-checking bench: supervisor and device joined by the link
// Assumes a second device without serial bus on a bench-driven link
`timescale 1ns/1ps
module tb_top;
  import hsep_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] e;} hsep_row_t;
  logic        clk;
  logic        rst_n;
  logic [7:0]  d_addr, d_wdata, d_rdata, b_rdata, s_addr, s_wdata, s_rdata;
  logic        d_wr, d_rd, s_wr, s_rd, s_busy, wake, bus_addr_v, addr_oe, cpu_rst_n, ram_kept;
  logic [7:0]  p_out, p_oe, pin_out, pin_oe, pin_pu, ra, rb;
  logic [15:0] bus_addr, addr_out;
  int          n_fail;
  int          n_tests;
  hsep_row_t   rows [6] = '{'{8'h02, 8'h3c, 8'h3c}, '{8'h03, 8'hc3, 8'hc3}, '{8'h04, 8'h5a, 8'h5a},
                            '{8'h05, 8'h0f, 8'h0f}, '{8'h06, 8'h77, 8'h00}, '{8'h00, 8'h01, 8'h01}};

  hsep_link_if hsep_link_if_inst ();
  hsep_link_if hsep_link_if_inst_b ();
  hsep_supervisor hsep_supervisor_inst (.clk(clk), .rst_n(rst_n), .link(hsep_link_if_inst), .reg_addr(s_addr),
    .reg_wdata(s_wdata), .reg_wr(s_wr), .reg_rd(s_rd), .reg_rdata(s_rdata), .busy(s_busy));
  hsep_device hsep_device_inst (.clk(clk), .rst_n(rst_n), .link(hsep_link_if_inst), .reg_addr(d_addr),
    .reg_wdata(d_wdata), .reg_wr(d_wr), .reg_rd(d_rd), .reg_rdata(d_rdata), .wake(wake), .periph_out(p_out),
    .periph_oe(p_oe), .bus_addr(bus_addr), .bus_addr_valid(bus_addr_v), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pin_pu), .addr_out(addr_out), .addr_oe(addr_oe), .cpu_reset_n(cpu_rst_n), .ram_kept(ram_kept));
  hsep_device #(.SB_PRESENT(1'b0)) hsep_device_inst_b (.clk(clk), .rst_n(rst_n), .link(hsep_link_if_inst_b),
    .reg_addr(d_addr), .reg_wdata(d_wdata), .reg_wr(d_wr), .reg_rd(d_rd), .reg_rdata(b_rdata), .wake(wake),
    .periph_out(p_out), .periph_oe(p_oe), .bus_addr(bus_addr), .bus_addr_valid(bus_addr_v), .pin_out(),
    .pin_oe(), .pin_pullup_en(), .addr_out(), .addr_oe(), .cpu_reset_n(), .ram_kept());
  hsep_checker hsep_checker_inst (.clk(clk), .rst_n(rst_n),
    .external_reset_pin_n(hsep_link_if_inst.external_reset_pin_n),
    .standby_request_pin_n(hsep_link_if_inst.standby_request_pin_n));

  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic dwr(input logic [7:0] a, input logic [7:0] w);
    @(posedge clk);
    d_addr  <= a;
    d_wdata <= w;
    d_wr    <= 1'b1;
    @(posedge clk);
    d_wr    <= 1'b0;
  endtask

  task automatic drd(input logic [7:0] a);
    @(posedge clk);
    d_addr <= a;
    d_rd   <= 1'b1;
    @(posedge clk);
    d_rd   <= 1'b0;
    #1;
    ra = d_rdata;
    rb = b_rdata;
  endtask

  task automatic srd;
    @(posedge clk);
    s_addr <= 8'h01;
    s_rd   <= 1'b1;
    @(posedge clk);
    s_rd   <= 1'b0;
    #1;
    ra = s_rdata;
  endtask

  task automatic swr(input logic [7:0] w);
    @(posedge clk);
    s_addr  <= 8'h00;
    s_wdata <= w;
    s_wr    <= 1'b1;
    @(posedge clk);
    s_wr    <= 1'b0;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 200 && s_busy !== 1'b0; i++) @(posedge clk);
  endtask

  task automatic wait_run;
    for (int i = 0; i < 200 && cpu_rst_n !== 1'b1; i++) @(posedge clk);
    #1;
  endtask

  task automatic close_out;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial
  begin
    #40000;
    n_fail++;
    close_out();
  end

  initial
  begin
    n_fail = 0;
    n_tests = 0;
    rst_n = 1'b0;
    {d_addr, d_wdata, d_wr, d_rd, s_addr, s_wdata, s_wr, s_rd, wake} = '0;
    p_out = 8'h00;
    p_oe = 8'hff;
    bus_addr = 16'h1234;
    bus_addr_v = 1'b1;
    hsep_link_if_inst_b.external_reset_pin_n = 1'b1;
    hsep_link_if_inst_b.standby_request_pin_n = 1'b1;
    repeat (12) @(posedge clk);
    chk({pin_oe, pin_pu}, 16'h0000);
    chk({addr_oe, cpu_rst_n, ram_kept}, 16'h0000);
    rst_n <= 1'b1;
    wait_run();
    foreach (rows[i])
    begin
      dwr(rows[i].a, rows[i].w);
      drd(rows[i].a);
      chk(ra, rows[i].e);
      chk(rb, rows[i].e);
    end
    // Bench-only probe of serial bus registers, present on the first device and absent on the second
    for (int a = 8; a < 12; a++)
    begin
      dwr(a[7:0], 8'h5a);
      drd(a[7:0]);
      chk(rb, 8'hff);
      chk(ra, 8'h5a);
    end
    // Pin setup: pin0 peripheral, pins 1..3 port outputs, 4..7 pulled inputs
    dwr(8'h02, 8'h0f);
    dwr(8'h03, 8'ha5);
    dwr(8'h04, 8'hf0);
    dwr(8'h05, 8'h01);
    repeat (3) @(posedge clk);
    chk({pin_oe, pin_out & pin_oe}, 16'h0f04);
    chk(addr_out, 16'h1234);
    dwr(8'h00, 8'h03);
    bus_addr <= 16'hbeef;
    repeat (4) @(posedge clk);
    drd(8'h01);
    chk(ra, 8'h01);
    chk({pin_oe, pin_out & pin_oe}, 16'h0f05);
    chk(pin_pu, 8'hf0);
    chk({addr_oe, addr_out}, 17'h11234);
    wake <= 1'b1;
    repeat (4) @(posedge clk);
    wake <= 1'b0;
    drd(8'h01);
    chk(ra, 8'h00);
    swr(8'h03);
    repeat (6) @(posedge clk);
    chk({pin_oe, 6'h00, cpu_rst_n, ram_kept}, 16'h0001);
    srd();
    chk(ra, 8'h0b);
    swr(8'h04);
    wait_run();
    chk(cpu_rst_n, 1'b1);
    drd(8'h01);
    chk(ra, 8'h08);
    drd(8'h00);
    chk(ra, 8'h00);
    swr(8'h01);
    repeat (6) @(posedge clk);
    chk({pin_oe, 6'h00, cpu_rst_n, ram_kept}, 16'h0000);
    srd();
    chk(ra, 8'h03);
    swr(8'h04);
    wait_run();
    drd(8'h01);
    chk(ra, 8'h00);
    close_out();
  end
endmodule
